// file: hdl/bpo_port_option.sv
// port option register, retry command matching, write conversion and request hold
// Summary of operation
// - primary read-line or read-multiple retry matches pending plain read when bit 1 set.
// - primary write-invalidate retry matches pending non-posted plain write when bit 2 set.
// - secondary read-line or read-multiple retry matches pending plain read when bit 3 set.
// - secondary write-invalidate retry matches pending non-posted plain write when bit 4 set.
// - primary read-line and read-multiple match each other when bit 5 set.
// - secondary read-line and read-multiple match each other when bit 6 set.
// - primary write-invalidate forwarded as plain write unless bit 7 set.
// - secondary write-invalidate forwarded as plain write unless bit 8 set.
// - bit 9 set selects long bus requests for locked cycles.
// - bit 10 set holds secondary request until queue empty or target stops.
// - bit 11 set holds primary request until queue empty or target stops.
// - reserved bits 0 and 15:12 read zero and reset zero.
// - capability identifier reads constant 01h in bits 7:0.
module bpo_port_option
	import bpo_pkg::*;
(
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// primary retry compare
	input  wire logic        p_cmp_i,
	input  wire logic        p_pend_posted_i,
	input  wire logic [3:0]  p_pend_cmd_i,
	input  wire logic [3:0]  p_retry_cmd_i,
	output logic             p_match_o,
	// secondary retry compare
	input  wire logic        s_cmp_i,
	input  wire logic        s_pend_posted_i,
	input  wire logic [3:0]  s_pend_cmd_i,
	input  wire logic [3:0]  s_retry_cmd_i,
	output logic             s_match_o,
	// write forwarding
	input  wire logic [3:0]  p_acc_cmd_i,
	input  wire logic [3:0]  s_acc_cmd_i,
	output logic      [3:0]  p_fwd_cmd_o,
	output logic      [3:0]  s_fwd_cmd_o,
	// lock
	output logic             lock_long_o,
	// primary internal master
	input  wire logic        p_start_i,
	input  wire logic        p_frame_i,
	input  wire logic        p_queue_empty_i,
	input  wire logic        p_target_term_i,
	output logic             p_req_n_o,
	// secondary internal master
	input  wire logic        s_start_i,
	input  wire logic        s_frame_i,
	input  wire logic        s_queue_empty_i,
	input  wire logic        s_target_term_i,
	output logic             s_req_n_o
);

	bpo_state_type st_r;
	bpo_state_type st_nxt;

	// retry compare with alias controls
	function automatic logic cmd_match(
		input logic [3:0] pend,
		input logic [3:0] retry,
		input logic       posted,
		input logic       rd_alias,
		input logic       wr_alias,
		input logic       lm_alias
	);
		logic rl;
		logic pl;
		rl = (retry == read_line_cmd) || (retry == read_multiple_cmd);
		pl = (pend == read_line_cmd) || (pend == read_multiple_cmd);
		cmd_match = (pend == retry);
		if (rd_alias && rl && (pend == plain_memory_read_cmd)) begin
			cmd_match = 1'b1;
		end
		if (lm_alias && rl && pl) begin
			cmd_match = 1'b1;
		end
		if (wr_alias && !posted && (retry == write_invalidate_cmd)
			&& (pend == plain_memory_write_cmd)) begin
			cmd_match = 1'b1;
		end
		return cmd_match;
	endfunction

	function automatic logic [3:0] fwd_cmd(input logic [3:0] cmd, input logic keep);
		if (!keep && cmd == write_invalidate_cmd) begin
			return plain_memory_write_cmd;
		end
		return cmd;
	endfunction

	function automatic logic [31:0] rd_data(input logic [7:0] adr, input logic [15:0] opt);
		case (adr)
			PORT_OPT_OFS: rd_data = {16'h0000, opt};
			// constant capability id
			// fixed id value
			CAP_ID_OFS:   rd_data = {24'h000000, CAP_ID_VAL};
			default:      rd_data = 32'h00000000;
		endcase
	endfunction

	logic        req;
	logic [15:0] wmask;

	always_comb begin
		st_nxt = st_r;
		req = wb_cyc_i && wb_stb_i;
		wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & PORT_OPT_WMASK;
		st_nxt.ack = 1'b0;
		case (st_r.bus)
			BPO_IDLE: begin
				if (req) begin
					st_nxt.ack = 1'b1;
					st_nxt.bus = BPO_ACK;
					st_nxt.dat = rd_data(wb_adr_i, st_r.opt);
					if (wb_we_i && wb_adr_i == PORT_OPT_OFS) begin
						st_nxt.opt = (st_r.opt & ~wmask) | (wb_dat_i[15:0] & wmask);
					end
				end
			end
			BPO_ACK: begin
				st_nxt.bus = BPO_IDLE;
			end
			default: begin
				st_nxt.bus = BPO_IDLE;
			end
		endcase
		// results latched per compare from current setting
		if (p_cmp_i) begin
			st_nxt.p_match = cmd_match(p_pend_cmd_i, p_retry_cmd_i, p_pend_posted_i,
				st_r.opt[P_RD_ALIAS], st_r.opt[P_WR_ALIAS], st_r.opt[P_LM_ALIAS]);
		end else begin
			st_nxt.p_match = 1'b0;
		end
		if (s_cmp_i) begin
			st_nxt.s_match = cmd_match(s_pend_cmd_i, s_retry_cmd_i, s_pend_posted_i,
				st_r.opt[S_RD_ALIAS], st_r.opt[S_WR_ALIAS], st_r.opt[S_LM_ALIAS]);
		end else begin
			st_nxt.s_match = 1'b0;
		end
		st_nxt.p_fwd_cmd = fwd_cmd(p_acc_cmd_i, st_r.opt[P_WI_KEEP]);
		st_nxt.s_fwd_cmd = fwd_cmd(s_acc_cmd_i, st_r.opt[S_WI_KEEP]);
		st_nxt.lock_long = st_r.opt[LONG_LOCK];
		if (p_start_i) begin
			st_nxt.p_req_on = 1'b1;
		end else if (st_r.p_req_on) begin
			if (st_r.opt[P_HOLD_REQ]) begin
				if (p_queue_empty_i || p_target_term_i) begin
					st_nxt.p_req_on = 1'b0;
				end
			end else if (p_frame_i) begin
				st_nxt.p_req_on = 1'b0;
			end
		end
		if (s_start_i) begin
			st_nxt.s_req_on = 1'b1;
		end else if (st_r.s_req_on) begin
			if (st_r.opt[S_HOLD_REQ]) begin
				if (s_queue_empty_i || s_target_term_i) begin
					st_nxt.s_req_on = 1'b0;
				end
			end else if (s_frame_i) begin
				st_nxt.s_req_on = 1'b0;
			end
		end
		st_nxt.p_req_n = !st_nxt.p_req_on;
		st_nxt.s_req_n = !st_nxt.s_req_on;
		if (rst_i) begin
			st_nxt = '0;
			st_nxt.bus = BPO_IDLE;
			st_nxt.opt = PORT_OPT_RST;
			st_nxt.p_req_n = 1'b1;
			st_nxt.s_req_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		st_r <= st_nxt;
	end

	assign wb_dat_o    = st_r.dat;
	assign wb_ack_o    = st_r.ack;
	assign p_match_o   = st_r.p_match;
	assign s_match_o   = st_r.s_match;
	assign p_fwd_cmd_o = st_r.p_fwd_cmd;
	assign s_fwd_cmd_o = st_r.s_fwd_cmd;
	assign lock_long_o = st_r.lock_long;
	assign p_req_n_o   = st_r.p_req_n;
	assign s_req_n_o   = st_r.s_req_n;

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r.opt[0] == 1'b0) && (st_r.opt[15:12] == 4'h0))
		else $error("reserved option bits not zero");
	a_cap_id_read: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && st_r.bus == BPO_IDLE && wb_adr_i == CAP_ID_OFS)
		|=> wb_ack_o && wb_dat_o == {24'h000000, CAP_ID_VAL})
		else $error("capability id read wrong");
	a_p_read_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && st_r.opt[P_RD_ALIAS] && p_pend_cmd_i == plain_memory_read_cmd
		&& p_retry_cmd_i == read_line_cmd) |=> p_match_o)
		else $error("primary read alias missed");
	a_p_write_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && !st_r.opt[P_WR_ALIAS] && p_pend_cmd_i == plain_memory_write_cmd
		&& p_retry_cmd_i == write_invalidate_cmd) |=> !p_match_o)
		else $error("primary write matched without alias");
	a_s_read_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cmp_i && !st_r.opt[S_RD_ALIAS] && !st_r.opt[S_LM_ALIAS]
		&& s_pend_cmd_i == plain_memory_read_cmd
		&& s_retry_cmd_i == read_multiple_cmd) |=> !s_match_o)
		else $error("secondary read matched without alias");
	a_s_write_alias: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cmp_i && st_r.opt[S_WR_ALIAS] && !s_pend_posted_i
		&& s_pend_cmd_i == plain_memory_write_cmd
		&& s_retry_cmd_i == write_invalidate_cmd) |=> s_match_o)
		else $error("secondary write alias missed");
	a_p_wi_convert: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_acc_cmd_i == write_invalidate_cmd && !st_r.opt[P_WI_KEEP])
		|=> p_fwd_cmd_o == plain_memory_write_cmd)
		else $error("primary write invalidate not converted");
	a_s_wi_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_acc_cmd_i == write_invalidate_cmd && st_r.opt[S_WI_KEEP])
		|=> s_fwd_cmd_o == write_invalidate_cmd)
		else $error("secondary write invalidate altered");
	a_p_req_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(!p_start_i && st_r.p_req_on && !st_r.opt[P_HOLD_REQ] && p_frame_i)
		|=> p_req_n_o)
		else $error("primary request not released after frame");
	a_s_req_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!s_start_i && st_r.s_req_on && st_r.opt[S_HOLD_REQ] && !s_queue_empty_i
		&& !s_target_term_i) |=> !s_req_n_o)
		else $error("secondary request dropped early");
	a_lock_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 lock_long_o == $past(st_r.opt[LONG_LOCK]))
		else $error("long lock output wrong");

	// bus handshake and reset state
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && st_r.bus == BPO_IDLE) |=> wb_ack_o)
		else $error("request not acknowledged");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_opt_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && st_r.bus == BPO_IDLE && wb_adr_i == PORT_OPT_OFS)
		|=> wb_ack_o && wb_dat_o[31:12] == 20'h00000 && wb_dat_o[0] == 1'b0)
		else $error("reserved option bits read nonzero");
	a_reset_values: assert property (@(posedge clk_i)
		rst_i |=> st_r.opt == PORT_OPT_RST && p_req_n_o && s_req_n_o
		&& !lock_long_o && !wb_ack_o)
		else $error("reset state wrong");

	// retry compare, other polarity of each read and write alias bit, both polarities of each line multiple bit
	a_p_read_exact: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && !st_r.opt[P_RD_ALIAS] && p_pend_cmd_i == plain_memory_read_cmd
		&& p_retry_cmd_i == read_multiple_cmd) |=> !p_match_o)
		else $error("primary read matched without alias");
	a_p_write_hit: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && st_r.opt[P_WR_ALIAS] && !p_pend_posted_i
		&& p_pend_cmd_i == plain_memory_write_cmd
		&& p_retry_cmd_i == write_invalidate_cmd) |=> p_match_o)
		else $error("primary write alias missed");
	a_p_posted_exact: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && p_pend_posted_i && p_pend_cmd_i == plain_memory_write_cmd
		&& p_retry_cmd_i == write_invalidate_cmd) |=> !p_match_o)
		else $error("posted primary write aliased");
	a_s_read_hit: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cmp_i && st_r.opt[S_RD_ALIAS] && s_pend_cmd_i == plain_memory_read_cmd
		&& s_retry_cmd_i == read_line_cmd) |=> s_match_o)
		else $error("secondary read alias missed");
	a_s_write_exact: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cmp_i && !st_r.opt[S_WR_ALIAS] && s_pend_cmd_i == plain_memory_write_cmd
		&& s_retry_cmd_i == write_invalidate_cmd) |=> !s_match_o)
		else $error("secondary write matched without alias");
	a_p_lm_hit: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && st_r.opt[P_LM_ALIAS] && p_pend_cmd_i == read_line_cmd
		&& p_retry_cmd_i == read_multiple_cmd) |=> p_match_o)
		else $error("primary line multiple alias missed");
	a_p_lm_exact: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_cmp_i && !st_r.opt[P_LM_ALIAS] && p_pend_cmd_i == read_multiple_cmd
		&& p_retry_cmd_i == read_line_cmd) |=> !p_match_o)
		else $error("primary line multiple matched without alias");
	a_s_lm_hit: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cmp_i && st_r.opt[S_LM_ALIAS] && s_pend_cmd_i == read_multiple_cmd
		&& s_retry_cmd_i == read_line_cmd) |=> s_match_o)
		else $error("secondary line multiple alias missed");
	a_s_lm_exact: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cmp_i && !st_r.opt[S_LM_ALIAS] && s_pend_cmd_i == read_line_cmd
		&& s_retry_cmd_i == read_multiple_cmd) |=> !s_match_o)
		else $error("secondary line multiple matched without alias");
	a_match_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(!p_cmp_i && !s_cmp_i) |=> !p_match_o && !s_match_o)
		else $error("match without compare");

	// write forwarding
	a_p_wi_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_acc_cmd_i == write_invalidate_cmd && st_r.opt[P_WI_KEEP])
		|=> p_fwd_cmd_o == write_invalidate_cmd)
		else $error("primary write invalidate altered");
	a_p_fwd_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		(p_acc_cmd_i != write_invalidate_cmd) |=> p_fwd_cmd_o == $past(p_acc_cmd_i))
		else $error("primary command altered");
	a_s_wi_convert: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_acc_cmd_i == write_invalidate_cmd && !st_r.opt[S_WI_KEEP])
		|=> s_fwd_cmd_o == plain_memory_write_cmd)
		else $error("secondary write invalidate not converted");
	a_s_fwd_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_acc_cmd_i != write_invalidate_cmd) |=> s_fwd_cmd_o == $past(s_acc_cmd_i))
		else $error("secondary command altered");

	// request hold and release
	a_p_start_req: assert property (@(posedge clk_i) disable iff (rst_i)
		p_start_i |=> !p_req_n_o)
		else $error("primary request not raised");
	a_s_start_req: assert property (@(posedge clk_i) disable iff (rst_i)
		s_start_i |=> !s_req_n_o)
		else $error("secondary request not raised");
	a_p_req_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		(!p_start_i && st_r.p_req_on && st_r.opt[P_HOLD_REQ] && !p_queue_empty_i
		&& !p_target_term_i) |=> !p_req_n_o)
		else $error("primary request dropped early");
	a_p_req_drain: assert property (@(posedge clk_i) disable iff (rst_i)
		(!p_start_i && st_r.p_req_on && st_r.opt[P_HOLD_REQ]
		&& (p_queue_empty_i || p_target_term_i)) |=> p_req_n_o)
		else $error("primary request held after drain");
	a_s_req_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(!s_start_i && st_r.s_req_on && !st_r.opt[S_HOLD_REQ] && s_frame_i)
		|=> s_req_n_o)
		else $error("secondary request not released after frame");
	a_s_req_drain: assert property (@(posedge clk_i) disable iff (rst_i)
		(!s_start_i && st_r.s_req_on && st_r.opt[S_HOLD_REQ]
		&& (s_queue_empty_i || s_target_term_i)) |=> s_req_n_o)
		else $error("secondary request held after drain");
endmodule

// file: hdl/bpo_pkg.sv
// constants for the bridge port option control block
package bpo_pkg;
	localparam logic [7:0]  PORT_OPT_OFS   = 8'h74;
	localparam logic [7:0]  CAP_ID_OFS     = 8'h80;
	localparam logic [7:0]  CAP_ID_VAL     = 8'h01;
	localparam logic [15:0] PORT_OPT_RST   = 16'h0c6a;
	localparam logic [15:0] PORT_OPT_WMASK = 16'h0ffe;
	localparam int P_RD_ALIAS  = 1;
	localparam int P_WR_ALIAS  = 2;
	localparam int S_RD_ALIAS  = 3;
	localparam int S_WR_ALIAS  = 4;
	localparam int P_LM_ALIAS  = 5;
	localparam int S_LM_ALIAS  = 6;
	localparam int P_WI_KEEP   = 7;
	localparam int S_WI_KEEP   = 8;
	localparam int LONG_LOCK   = 9;
	localparam int S_HOLD_REQ  = 10;
	localparam int P_HOLD_REQ  = 11;
	localparam logic [3:0] plain_memory_read_cmd  = 4'h6;
	localparam logic [3:0] plain_memory_write_cmd = 4'h7;
	localparam logic [3:0] read_multiple_cmd      = 4'hc;
	localparam logic [3:0] read_line_cmd          = 4'he;
	localparam logic [3:0] write_invalidate_cmd   = 4'hf;
	typedef enum logic [1:0] {
		BPO_IDLE = 2'b00,
		BPO_ACK  = 2'b01
	} bpo_bus_type;
	typedef struct packed {
		bpo_bus_type bus;
		logic        ack;
		logic [31:0] dat;
		logic [15:0] opt;
		logic        p_match;
		logic        s_match;
		logic [3:0]  p_fwd_cmd;
		logic [3:0]  s_fwd_cmd;
		logic        lock_long;
		logic        p_req_n;
		logic        s_req_n;
		logic        p_req_on;
		logic        s_req_on;
	} bpo_state_type;
endpackage

// file: testbench/bpo_pci_model.sv
// bus model: grants a request with a frame and may stop the master
module bpo_pci_model (
	// system
	input  wire logic clk_i,
	input  wire logic rst_i,
	// master side
	input  wire logic req_n_i,
	input  wire logic term_en_i,
	output logic      frame_o,
	output logic      term_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_r;
	// frame two cycles after request, for at most four cycles, gone one cycle after request drops
	always_ff @(posedge clk_i) begin
		if (rst_i || req_n_i) begin
			cnt_r <= 3'h0;
		end else if (cnt_r != 3'h7) begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
	assign frame_o = (cnt_r >= 3'h2) && (cnt_r < 3'h6);
	assign term_o  = term_en_i && (cnt_r == 3'h5);
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the port option block
module tb_top
	import bpo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cd, term_en;
	logic        p_cmp_i, s_cmp_i, p_pend_posted_i, s_pend_posted_i, p_match_o, s_match_o;
	logic        lock_long_o, p_start_i, p_frame_i, p_queue_empty_i, p_target_term_i;
	logic        s_start_i, s_frame_i, s_queue_empty_i, s_target_term_i, p_req_n_o, s_req_n_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, p_pend_cmd_i, p_retry_cmd_i, s_pend_cmd_i, s_retry_cmd_i;
	logic [3:0]  p_acc_cmd_i, s_acc_cmd_i, p_fwd_cmd_o, s_fwd_cmd_o;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [31:0] rq[$];
	logic [9:0]  mq[$];
	logic [9:0]  mexp;
	logic [15:0] opt;
	int          err_total, tests_run;
	logic [3:0]  cmds[5] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf};

	bpo_port_option uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .p_cmp_i, .p_pend_posted_i, .p_pend_cmd_i,
		.p_retry_cmd_i, .p_match_o, .s_cmp_i, .s_pend_posted_i, .s_pend_cmd_i, .s_retry_cmd_i,
		.s_match_o, .p_acc_cmd_i, .s_acc_cmd_i, .p_fwd_cmd_o, .s_fwd_cmd_o, .lock_long_o,
		.p_start_i, .p_frame_i, .p_queue_empty_i, .p_target_term_i, .p_req_n_o, .s_start_i,
		.s_frame_i, .s_queue_empty_i, .s_target_term_i, .s_req_n_o);
	bpo_pci_model pm_p (.clk_i, .rst_i, .req_n_i(p_req_n_o), .term_en_i(term_en),
		.frame_o(p_frame_i), .term_o(p_target_term_i));
	bpo_pci_model pm_s (.clk_i, .rst_i, .req_n_i(s_req_n_o), .term_en_i(term_en),
		.frame_o(s_frame_i), .term_o(s_target_term_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [3:0] s);
		if (!we) rq.push_back(e);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// expected retry match and forwarded command
	function automatic logic em(logic [3:0] pd, logic [3:0] rt, logic po, logic rd, logic wr,
		logic lm);
		logic rl, pl;
		rl = (rt == read_line_cmd) || (rt == read_multiple_cmd);
		pl = (pd == read_line_cmd) || (pd == read_multiple_cmd);
		return (rt == pd) || (rd && rl && pd == plain_memory_read_cmd) || (lm && rl && pl)
			|| (wr && !po && pd == plain_memory_write_cmd && rt == write_invalidate_cmd);
	endfunction
	function automatic logic [3:0] ef(logic [3:0] c, logic k);
		return (c == write_invalidate_cmd && !k) ? plain_memory_write_cmd : c;
	endfunction

	always @(posedge clk_i) begin
		if (wb_ack_o && !wb_we_i && rq.size() > 0) chk(wb_dat_o, rq.pop_front());
		if (cd && mq.size() > 0) begin
			mexp = mq.pop_front();
			chk({p_match_o, s_match_o}, mexp[9:8]);
			chk({p_fwd_cmd_o, s_fwd_cmd_o}, mexp[7:0]);
		end
		cd <= p_cmp_i;
	end

	task automatic cmp_run(input logic [15:0] o);
		logic [3:0] a, b, c, d, e, f;
		logic       x, y;
		wb(1'b1, PORT_OPT_OFS, {16'h0, o}, 32'h0, 4'hf);
		opt = o & 16'h0ffe;
		chk(lock_long_o, opt[LONG_LOCK]);
		repeat (40) begin
			a = cmds[$urandom % 5];
			b = cmds[$urandom % 5];
			c = cmds[$urandom % 5];
			d = cmds[$urandom % 5];
			e = cmds[$urandom % 5];
			f = cmds[$urandom % 5];
			x = 1'($urandom);
			y = 1'($urandom);
			p_cmp_i <= 1'b1;
			s_cmp_i <= 1'b1;
			p_pend_cmd_i <= a;
			p_retry_cmd_i <= b;
			s_pend_cmd_i <= c;
			s_retry_cmd_i <= d;
			p_pend_posted_i <= x;
			s_pend_posted_i <= y;
			p_acc_cmd_i <= e;
			s_acc_cmd_i <= f;
			mq.push_back({em(a, b, x, opt[P_RD_ALIAS], opt[P_WR_ALIAS], opt[P_LM_ALIAS]),
				em(c, d, y, opt[S_RD_ALIAS], opt[S_WR_ALIAS], opt[S_LM_ALIAS]),
				ef(e, opt[P_WI_KEEP]), ef(f, opt[S_WI_KEEP])});
			@(posedge clk_i);
		end
		p_cmp_i <= 1'b0;
		s_cmp_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic req_run(input logic h, input logic m);
		wb(1'b1, PORT_OPT_OFS, {20'h0, h, h, 10'h06a}, 32'h0, 4'hf);
		p_queue_empty_i <= 1'b0;
		s_queue_empty_i <= 1'b0;
		term_en <= m;
		p_start_i <= 1'b1;
		s_start_i <= 1'b1;
		@(posedge clk_i);
		p_start_i <= 1'b0;
		s_start_i <= 1'b0;
		do @(posedge clk_i); while (p_frame_i !== 1'b1);
		@(posedge clk_i);
		chk({p_req_n_o, s_req_n_o}, {!h, !h});
		if (h && !m) begin
			p_queue_empty_i <= 1'b1;
			s_queue_empty_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			chk({p_req_n_o, s_req_n_o}, 2'b11);
		end else if (h) begin
			repeat (2) @(posedge clk_i);
			chk({p_req_n_o, s_req_n_o}, 2'b00);
			@(posedge clk_i);
			chk({p_req_n_o, s_req_n_o}, 2'b11);
		end
		p_queue_empty_i <= 1'b1;
		s_queue_empty_i <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, cd, term_en} = '0;
		{p_cmp_i, s_cmp_i, p_pend_posted_i, s_pend_posted_i, p_start_i, s_start_i} = '0;
		{p_pend_cmd_i, p_retry_cmd_i, s_pend_cmd_i, s_retry_cmd_i} = '0;
		{p_acc_cmd_i, s_acc_cmd_i, err_total, tests_run} = '0;
		p_queue_empty_i = 1'b1;
		s_queue_empty_i = 1'b1;
		rst_i = 1'b1;
		void'($urandom(32'hee9b));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({lock_long_o, p_req_n_o, s_req_n_o, wb_ack_o}, 4'b0110);
		wb(1'b0, PORT_OPT_OFS, 32'h0, 32'h0c6a, 4'hf);
		wb(1'b0, CAP_ID_OFS, 32'h0, 32'h01, 4'hf);
		wb(1'b0, 8'h78, 32'h0, 32'h0, 4'hf);
		wb(1'b1, PORT_OPT_OFS, 32'hffffffff, 32'h0, 4'hf);
		wb(1'b0, PORT_OPT_OFS, 32'h0, 32'h0ffe, 4'hf);
		wb(1'b1, PORT_OPT_OFS, 32'h0, 32'h0, 4'h2);
		wb(1'b0, PORT_OPT_OFS, 32'h0, 32'h00fe, 4'hf);
		wb(1'b1, CAP_ID_OFS, 32'hff, 32'h0, 4'hf);
		wb(1'b0, CAP_ID_OFS, 32'h0, 32'h01, 4'hf);
		$display("test registers done");
		// reset in mid-run restores the option register
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({lock_long_o, p_req_n_o, s_req_n_o, wb_ack_o}, 4'b0110);
		wb(1'b0, PORT_OPT_OFS, 32'h0, {16'h0000, PORT_OPT_RST}, 4'hf);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			cmp_run(i == 0 ? 16'h0c6a : i == 1 ? 16'hffff : i == 2 ? 16'h0 : 16'($urandom));
		end
		$display("test compare done");
		req_run(1'b0, 1'b0);
		req_run(1'b1, 1'b0);
		req_run(1'b1, 1'b1);
		$display("test request done");
		end_of_test();
	end

	initial begin
		#100000;
		err_total++;
		end_of_test();
	end
endmodule
